// ===== core/bfm_core.sv
`timescale 1ns/1ps
module bfm_core #(
  parameter int DEPTH = bfm_pkg::FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Port A
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_write_not_read,
  input wire logic i_port_a_mailbox_sel,
  input wire logic [35:0] i_port_a_data,
  output logic [35:0] o_port_a_data,
  output logic o_port_a_data_oe,
  output logic o_port_a_empty_n,
  output logic o_port_a_full_n,
  output logic o_port_a_almost_empty_n,
  output logic o_port_a_almost_full_n,
  // Port B
  input wire logic i_port_b_select_n,
  input wire logic i_port_b_write_not_read,
  input wire logic i_port_b_mailbox_sel,
  input wire logic i_bus_size_sel_lo,
  input wire logic i_bus_size_sel_hi,
  input wire logic i_swap_mode_lo,
  input wire logic i_swap_mode_hi,
  input wire logic i_big_endian,
  input wire logic [35:0] i_port_b_data,
  output logic [35:0] o_port_b_data,
  output logic o_port_b_data_oe,
  output logic o_port_b_empty_n,
  output logic o_port_b_full_n,
  output logic o_port_b_almost_empty_n,
  output logic o_port_b_almost_full_n,
  // Shared configuration
  input wire logic [35:0] i_mailbox_a_to_b,
  input wire logic [$clog2(DEPTH):0] i_almost_empty_level,
  input wire logic [$clog2(DEPTH):0] i_almost_full_level
);

  localparam int CW = $clog2(DEPTH) + 1;
  typedef logic [CW:0] bfm_wide_t;

  typedef struct packed {
    logic [35:0] a_bus;
    logic [35:0] b_bus;
    logic [35:0] b_rd_word;
    logic [1:0] b_rd_part;
    logic [35:0] b_wr_word;
    logic [1:0] b_wr_part;
    logic [7:0] flag;
    logic [7:0] hist1;
    logic [7:0] hist2;
  } bfm_core_s;

  bfm_core_s st_r;
  bfm_core_s st_nxt;

  bfm_pkg::bfm_size_e size;
  logic [1:0] swap_mode;
  logic [1:0] last_part;
  logic a_wr_req;
  logic a_rd_req;
  logic b_wr_req;
  logic b_rd_req;
  logic b_mail_req;
  logic a2b_push;
  logic a2b_pop;
  logic a2b_ready;
  logic a2b_valid;
  logic [35:0] a2b_dout;
  logic [CW-1:0] a2b_count;
  logic b2a_push;
  logic b2a_pop;
  logic b2a_ready;
  logic b2a_valid;
  logic [35:0] b2a_dout;
  logic [35:0] b2a_din;
  logic [CW-1:0] b2a_count;
  bfm_wide_t a2b_after;
  bfm_wide_t b2a_after;
  logic [7:0] raw;

  // ==========================================================
  // Lane helpers
  function automatic logic [35:0] bfm_swap(input logic [35:0] w, input logic [1:0] mode);
    logic [35:0] r;
    case (mode)
      bfm_pkg::SWAP_NONE: r = w;
      bfm_pkg::SWAP_BYTE_REV: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
      bfm_pkg::SWAP_HALF: r = {w[17:0], w[35:18]};
      bfm_pkg::SWAP_IN_HALF: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: r = w;
    endcase
    return r;
  endfunction : bfm_swap

  // Moves one part between the bus lane and its slot in the swapped word.
  // Bus lane is the top one for big-endian, the bottom one otherwise.
  function automatic logic [35:0] bfm_move(
    input logic [35:0] dst,
    input logic [35:0] src,
    input bfm_pkg::bfm_size_e sz,
    input logic big,
    input logic [1:0] p,
    input logic to_bus
  );
    logic [35:0] r;
    int seg;
    int lane;
    r = dst;
    seg = 0;
    lane = 0;
    case (sz)
      bfm_pkg::BFM_SIZE_WORD: begin
        seg = big ? (1 - int'(p[0])) : int'(p[0]);
        lane = big ? 1 : 0;
        if (to_bus) begin
          r[lane*bfm_pkg::HALF_W +: bfm_pkg::HALF_W] = src[seg*bfm_pkg::HALF_W +: bfm_pkg::HALF_W];
        end else begin
          r[seg*bfm_pkg::HALF_W +: bfm_pkg::HALF_W] = src[lane*bfm_pkg::HALF_W +: bfm_pkg::HALF_W];
        end
      end
      bfm_pkg::BFM_SIZE_BYTE: begin
        seg = big ? (3 - int'(p)) : int'(p);
        lane = big ? 3 : 0;
        if (to_bus) begin
          r[lane*bfm_pkg::LANE_W +: bfm_pkg::LANE_W] = src[seg*bfm_pkg::LANE_W +: bfm_pkg::LANE_W];
        end else begin
          r[seg*bfm_pkg::LANE_W +: bfm_pkg::LANE_W] = src[lane*bfm_pkg::LANE_W +: bfm_pkg::LANE_W];
        end
      end
      default: begin
        r = src;
      end
    endcase
    return r;
  endfunction : bfm_move

  // ==========================================================
  // Request decode
  assign size = bfm_pkg::bfm_size_e'({i_bus_size_sel_hi, i_bus_size_sel_lo});
  assign swap_mode = {i_swap_mode_hi, i_swap_mode_lo};
  assign a_wr_req = !i_port_a_select_n && i_port_a_write_not_read && !i_port_a_mailbox_sel;
  assign a_rd_req = !i_port_a_select_n && !i_port_a_write_not_read && !i_port_a_mailbox_sel;
  assign b_wr_req = !i_port_b_select_n && i_port_b_write_not_read && !i_port_b_mailbox_sel
                    && (size != bfm_pkg::BFM_SIZE_MAIL);
  assign b_rd_req = !i_port_b_select_n && !i_port_b_write_not_read && !i_port_b_mailbox_sel
                    && (size != bfm_pkg::BFM_SIZE_MAIL);
  assign b_mail_req = !i_port_b_select_n && !i_port_b_write_not_read
                      && (size == bfm_pkg::BFM_SIZE_MAIL);
  assign o_port_a_data_oe = !i_port_a_select_n && !i_port_a_write_not_read;
  assign o_port_b_data_oe = !i_port_b_select_n && !i_port_b_write_not_read;

  always_comb begin
    case (size)
      bfm_pkg::BFM_SIZE_LONG: last_part = bfm_pkg::LAST_PART_LONG;
      bfm_pkg::BFM_SIZE_WORD: last_part = bfm_pkg::LAST_PART_WORD;
      bfm_pkg::BFM_SIZE_BYTE: last_part = bfm_pkg::LAST_PART_BYTE;
      default: last_part = bfm_pkg::LAST_PART_LONG;
    endcase
  end

  // ==========================================================
  // FIFOs
  assign a2b_push = a_wr_req && a2b_ready;
  assign b2a_pop = a_rd_req && b2a_valid;
  // A new long word leaves the FIFO only on the first part of a read
  assign a2b_pop = b_rd_req && (st_r.b_rd_part == bfm_pkg::PART_RESET) && a2b_valid;
  // Partial writes are stored only when the last part completes the word
  assign b2a_push = b_wr_req && (st_r.b_wr_part == last_part) && b2a_ready;
  assign b2a_din = bfm_swap(bfm_move(st_r.b_wr_word, i_port_b_data, size, i_big_endian,
                                     st_r.b_wr_part, 1'b0), swap_mode);

  bfm_fifo #(
    .WIDTH(bfm_pkg::BUS_W),
    .DEPTH(DEPTH)
  ) u_fifo_a_to_b (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_wr_valid(a_wr_req),
    .o_wr_ready(a2b_ready),
    .i_wr_data(i_port_a_data),
    .o_rd_valid(a2b_valid),
    .i_rd_ready(a2b_pop),
    .o_rd_data(a2b_dout),
    .o_count(a2b_count)
  );

  bfm_fifo #(
    .WIDTH(bfm_pkg::BUS_W),
    .DEPTH(DEPTH)
  ) u_fifo_b_to_a (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_wr_valid(b2a_push),
    .o_wr_ready(b2a_ready),
    .i_wr_data(b2a_din),
    .o_rd_valid(b2a_valid),
    .i_rd_ready(b2a_pop),
    .o_rd_data(b2a_dout),
    .o_count(b2a_count)
  );

  // ==========================================================
  // Occupancy after this edge, so flags fall on the same edge
  assign a2b_after = bfm_wide_t'(a2b_count) + bfm_wide_t'(a2b_push) - bfm_wide_t'(a2b_pop);
  assign b2a_after = bfm_wide_t'(b2a_count) + bfm_wide_t'(b2a_push) - bfm_wide_t'(b2a_pop);

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;

    if (a_rd_req && b2a_valid) begin
      st_nxt.a_bus = b2a_dout;
    end

    if (b_mail_req) begin
      st_nxt.b_bus = i_mailbox_a_to_b;
    end else if (b_rd_req) begin
      if (st_r.b_rd_part == bfm_pkg::PART_RESET) begin
        if (a2b_valid) begin
          st_nxt.b_rd_word = bfm_swap(a2b_dout, swap_mode);
          // Lanes outside the part keep the previous output register value
          st_nxt.b_bus = bfm_move(st_r.b_bus, st_nxt.b_rd_word, size, i_big_endian,
                                  st_r.b_rd_part, 1'b1);
          st_nxt.b_rd_part = (last_part == bfm_pkg::PART_RESET) ? bfm_pkg::PART_RESET : 2'h1;
        end
      end else begin
        st_nxt.b_bus = bfm_move(st_r.b_bus, st_r.b_rd_word, size, i_big_endian,
                                st_r.b_rd_part, 1'b1);
        st_nxt.b_rd_part = (st_r.b_rd_part >= last_part) ? bfm_pkg::PART_RESET
                                                          : st_r.b_rd_part + 2'h1;
      end
    end

    if (b_wr_req) begin
      st_nxt.b_wr_word = bfm_move(st_r.b_wr_word, i_port_b_data, size, i_big_endian,
                                  st_r.b_wr_part, 1'b0);
      // A completed word that finds the FIFO full is dropped
      st_nxt.b_wr_part = (st_r.b_wr_part >= last_part) ? bfm_pkg::PART_RESET
                                                       : st_r.b_wr_part + 2'h1;
    end

    raw[bfm_pkg::FL_A_EMPTY] = (b2a_after != '0);
    raw[bfm_pkg::FL_A_FULL] = (a2b_after < bfm_wide_t'(DEPTH));
    raw[bfm_pkg::FL_A_AEMPTY] = (b2a_after > bfm_wide_t'(i_almost_empty_level));
    raw[bfm_pkg::FL_A_AFULL] = ((a2b_after + bfm_wide_t'(i_almost_full_level)) < bfm_wide_t'(DEPTH));
    // Empty on port B also covers parts still held in the output word
    raw[bfm_pkg::FL_B_EMPTY] = (a2b_after != '0) || (st_nxt.b_rd_part != bfm_pkg::PART_RESET);
    raw[bfm_pkg::FL_B_FULL] = (b2a_after < bfm_wide_t'(DEPTH));
    raw[bfm_pkg::FL_B_AEMPTY] = (a2b_after > bfm_wide_t'(i_almost_empty_level));
    raw[bfm_pkg::FL_B_AFULL] = ((b2a_after + bfm_wide_t'(i_almost_full_level)) < bfm_wide_t'(DEPTH));

    // Falls act at once; rises wait two stages so they appear late
    st_nxt.hist1 = raw;
    st_nxt.hist2 = st_r.hist1;
    for (int k = 0; k < bfm_pkg::FLAG_N; k++) begin
      st_nxt.flag[k] = raw[k] && st_r.hist1[k] && st_r.hist2[k];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_r.a_bus <= bfm_pkg::BUS_RESET;
      st_r.b_bus <= bfm_pkg::BUS_RESET;
      st_r.b_rd_word <= bfm_pkg::BUS_RESET;
      st_r.b_rd_part <= bfm_pkg::PART_RESET;
      st_r.b_wr_word <= bfm_pkg::BUS_RESET;
      st_r.b_wr_part <= bfm_pkg::PART_RESET;
      st_r.flag <= bfm_pkg::FLAGS_RESET;
      st_r.hist1 <= bfm_pkg::FLAGS_RESET;
      st_r.hist2 <= bfm_pkg::FLAGS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign o_port_a_data = st_r.a_bus;
  assign o_port_b_data = st_r.b_bus;
  assign o_port_a_empty_n = st_r.flag[bfm_pkg::FL_A_EMPTY];
  assign o_port_a_full_n = st_r.flag[bfm_pkg::FL_A_FULL];
  assign o_port_a_almost_empty_n = st_r.flag[bfm_pkg::FL_A_AEMPTY];
  assign o_port_a_almost_full_n = st_r.flag[bfm_pkg::FL_A_AFULL];
  assign o_port_b_empty_n = st_r.flag[bfm_pkg::FL_B_EMPTY];
  assign o_port_b_full_n = st_r.flag[bfm_pkg::FL_B_FULL];
  assign o_port_b_almost_empty_n = st_r.flag[bfm_pkg::FL_B_AEMPTY];
  assign o_port_b_almost_full_n = st_r.flag[bfm_pkg::FL_B_AFULL];

endmodule : bfm_core

// ===== core/bfm_pkg.sv
package bfm_pkg;

  // ==========================================================
  // Widths and depth
  localparam int BUS_W = 36;
  localparam int LANE_W = 9;
  localparam int HALF_W = 18;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================
  // Port-B bus size codes {hi, lo}
  typedef enum logic [1:0] {
    BFM_SIZE_LONG = 2'b00,
    BFM_SIZE_WORD = 2'b01,
    BFM_SIZE_BYTE = 2'b10,
    BFM_SIZE_MAIL = 2'b11
  } bfm_size_e;

  // Byte swap codes {hi, lo}
  localparam logic [1:0] SWAP_NONE = 2'b00;
  localparam logic [1:0] SWAP_BYTE_REV = 2'b01;
  localparam logic [1:0] SWAP_HALF = 2'b10;
  localparam logic [1:0] SWAP_IN_HALF = 2'b11;

  // Parts per long word, minus one
  localparam logic [1:0] LAST_PART_LONG = 2'h0;
  localparam logic [1:0] LAST_PART_WORD = 2'h1;
  localparam logic [1:0] LAST_PART_BYTE = 2'h3;

  // ==========================================================
  // Flag vector positions, all flags active low
  localparam int FLAG_N = 8;
  localparam int FL_A_EMPTY = 0;
  localparam int FL_A_FULL = 1;
  localparam int FL_A_AEMPTY = 2;
  localparam int FL_A_AFULL = 3;
  localparam int FL_B_EMPTY = 4;
  localparam int FL_B_FULL = 5;
  localparam int FL_B_AEMPTY = 6;
  localparam int FL_B_AFULL = 7;

  // ==========================================================
  // Reset values: empties asserted, fulls released
  localparam logic [7:0] FLAGS_RESET = 8'haa;
  localparam logic [35:0] BUS_RESET = 36'h0;
  localparam logic [1:0] PART_RESET = 2'h0;

endpackage : bfm_pkg

// ===== core/bfm_fifo.sv
`timescale 1ns/1ps
module bfm_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data,
  output logic [$clog2(DEPTH):0] o_count
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic out_valid;
    logic [WIDTH-1:0] dout;
  } bfm_fifo_s;

  bfm_fifo_s st_r;
  bfm_fifo_s st_nxt;
  logic [AW:0] mem_cnt;
  logic push;
  logic pop;
  logic load;

  // ==========================================================
  // Output register counts as storage, so total capacity is DEPTH
  assign mem_cnt = st_r.wr_ptr - st_r.rd_ptr;
  assign o_count = mem_cnt + {{AW{1'b0}}, st_r.out_valid};
  assign o_wr_ready = (o_count < (AW+1)'(DEPTH));
  assign o_rd_valid = st_r.out_valid;
  assign o_rd_data = st_r.dout;
  assign push = i_wr_valid && o_wr_ready;
  assign pop = st_r.out_valid && i_rd_ready;
  assign load = (mem_cnt != '0) && (!st_r.out_valid || pop);

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr[AW-1:0]] = i_wr_data;
      st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
    end
    if (load) begin
      st_nxt.dout = st_r.mem[st_r.rd_ptr[AW-1:0]];
      st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
      st_nxt.out_valid = 1'b1;
    end else if (pop) begin
      st_nxt.out_valid = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : bfm_fifo

// ===== testbench/bfm_host_model.sv
`timescale 1ns/1ps
module bfm_host_model (
  input wire logic i_ref_clk,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [35:0] i_word,
  output logic o_select_n,
  output logic o_write_not_read,
  output logic [35:0] o_data
);
  logic [35:0] last_r = 36'h0;
  // FIFO accesses only; the mailbox select is held low by the bench
  assign o_select_n = ~(i_wr | i_rd);
  assign o_write_not_read = i_wr;
  // Released bus shows the inverse of the last word, never a stale copy
  assign o_data = i_wr ? i_word : ~last_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_wr) begin
      last_r <= i_word;
    end
  end
endmodule : bfm_host_model

// ===== testbench/bfm_core_asserts.sv
`timescale 1ns/1ps
module bfm_core_asserts (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_write_not_read,
  input wire logic i_port_a_mailbox_sel,
  input wire logic i_port_b_select_n,
  input wire logic i_port_b_write_not_read,
  input wire logic i_port_b_mailbox_sel,
  input wire logic i_bus_size_sel_lo,
  input wire logic i_bus_size_sel_hi,
  input wire logic i_big_endian,
  input wire logic [35:0] i_mailbox_a_to_b,
  input wire logic [35:0] o_port_b_data,
  input wire logic o_port_a_empty_n,
  input wire logic o_port_a_full_n,
  input wire logic o_port_b_empty_n,
  input wire logic o_port_b_full_n
);
  logic a_wr, a_rd, b_rd, b_wr, b_mail, b_fifo;
  assign a_wr = !i_port_a_select_n && i_port_a_write_not_read && !i_port_a_mailbox_sel;
  assign a_rd = !i_port_a_select_n && !i_port_a_write_not_read && !i_port_a_mailbox_sel;
  assign b_fifo = !i_port_b_select_n && !i_port_b_mailbox_sel && !(i_bus_size_sel_hi && i_bus_size_sel_lo);
  assign b_rd = b_fifo && !i_port_b_write_not_read;
  assign b_wr = b_fifo && i_port_b_write_not_read;
  assign b_mail = !i_port_b_select_n && !i_port_b_write_not_read && i_bus_size_sel_hi && i_bus_size_sel_lo;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // ==========================================================
  // Read path
  property p_mail_out; b_mail |=> o_port_b_data == $past(i_mailbox_a_to_b); endproperty
  a_mail_out: assert property (p_mail_out) else $error("mailbox not driven on port b");
  property p_word_hold;
    b_rd && !i_bus_size_sel_hi && i_bus_size_sel_lo
      |=> ($past(i_big_endian) ? $stable(o_port_b_data[17:0]) : $stable(o_port_b_data[35:18]));
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("unused half changed on word read");
  property p_byte_hold;
    b_rd && i_bus_size_sel_hi && !i_bus_size_sel_lo
      |=> ($past(i_big_endian) ? $stable(o_port_b_data[26:0]) : $stable(o_port_b_data[35:9]));
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("unused lanes changed on byte read");

  // ==========================================================
  // Flags: falls at the causing edge; a release lands two edges later, seen three samples on
  property p_b_empty_fall; $fell(o_port_b_empty_n) |-> $past(b_rd); endproperty
  a_b_empty_fall: assert property (p_b_empty_fall) else $error("b empty fell without a read");
  property p_b_full_fall; $fell(o_port_b_full_n) |-> $past(b_wr); endproperty
  a_b_full_fall: assert property (p_b_full_fall) else $error("b full fell without a write");
  property p_b_empty_rel; $rose(o_port_b_empty_n) |-> $past(a_wr, 3); endproperty
  a_b_empty_rel: assert property (p_b_empty_rel) else $error("b empty released off time");
  property p_a_empty_rel; $rose(o_port_a_empty_n) |-> $past(b_wr, 3); endproperty
  a_a_empty_rel: assert property (p_a_empty_rel) else $error("a empty released off time");
  property p_a_full_rel; $rose(o_port_a_full_n) |-> $past(b_rd, 3); endproperty
  a_a_full_rel: assert property (p_a_full_rel) else $error("a full released off time");
  property p_b_full_rel; $rose(o_port_b_full_n) |-> $past(a_rd, 3); endproperty
  a_b_full_rel: assert property (p_b_full_rel) else $error("b full released off time");
endmodule : bfm_core_asserts

bind bfm_core bfm_core_asserts u_chk (.i_ref_clk, .i_reset, .i_port_a_select_n, .i_port_a_write_not_read,
  .i_port_a_mailbox_sel, .i_port_b_select_n, .i_port_b_write_not_read, .i_port_b_mailbox_sel,
  .i_bus_size_sel_lo, .i_bus_size_sel_hi, .i_big_endian, .i_mailbox_a_to_b, .o_port_b_data,
  .o_port_a_empty_n, .o_port_a_full_n, .o_port_b_empty_n, .o_port_b_full_n);

// ===== testbench/bidir_fifo_bus_match_flags_tb.sv
`timescale 1ns/1ps
module bidir_fifo_bus_match_flags_tb;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic a_wr = 1'b0, a_rd = 1'b0, b_sel_n = 1'b1, b_wnr = 1'b0, big = 1'b1, b_note = 1'b0, a_note = 1'b0;
  logic a_sel_n, a_wnr;
  logic [1:0] b_size = 2'h0, b_swap = 2'h0, sz;
  logic [35:0] a_word = 36'h0, b_data = 36'h0, mbx = 36'h0, a_bus, a_dout, b_dout, w, s, old;
  wire [3:0] fa, fb;
  wire a_oe, b_oe;
  logic [35:0] qa[$], qb[$], fw[16];
  logic bg;
  int fail_count = 0;
  int n_tests = 0;
  int np;

  always #12.5 i_ref_clk = ~i_ref_clk;

  bfm_host_model host (.i_ref_clk(i_ref_clk), .i_wr(a_wr), .i_rd(a_rd), .i_word(a_word),
    .o_select_n(a_sel_n), .o_write_not_read(a_wnr), .o_data(a_bus));

  bfm_core #(.DEPTH(16)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_port_a_select_n(a_sel_n),
    .i_port_a_write_not_read(a_wnr), .i_port_a_mailbox_sel(1'b0), .i_port_a_data(a_bus),
    .o_port_a_data(a_dout), .o_port_a_data_oe(a_oe), .o_port_a_empty_n(fa[0]), .o_port_a_full_n(fa[1]),
    .o_port_a_almost_empty_n(fa[2]), .o_port_a_almost_full_n(fa[3]), .i_port_b_select_n(b_sel_n),
    .i_port_b_write_not_read(b_wnr), .i_port_b_mailbox_sel(1'b0), .i_bus_size_sel_lo(b_size[0]),
    .i_bus_size_sel_hi(b_size[1]), .i_swap_mode_lo(b_swap[0]), .i_swap_mode_hi(b_swap[1]),
    .i_big_endian(big), .i_port_b_data(b_data), .o_port_b_data(b_dout), .o_port_b_data_oe(b_oe),
    .o_port_b_empty_n(fb[0]), .o_port_b_full_n(fb[1]), .o_port_b_almost_empty_n(fb[2]),
    .o_port_b_almost_full_n(fb[3]), .i_mailbox_a_to_b(mbx), .i_almost_empty_level(5'h02),
    .i_almost_full_level(5'h02));

  // ==========================================================
  // Helpers
  function automatic logic [35:0] sw(logic [35:0] v, logic [1:0] m);
    case (m)
      2'h1: return {v[8:0], v[17:9], v[26:18], v[35:27]};
      2'h2: return {v[17:0], v[35:18]};
      2'h3: return {v[26:18], v[35:27], v[8:0], v[17:9]};
      default: return v;
    endcase
  endfunction : sw

  // Unused lanes keep the previous output value
  function automatic logic [35:0] part(logic [35:0] o, logic [35:0] v, logic [1:0] z, logic e, int p);
    logic [35:0] r;
    r = o;
    if (z == 2'h0) r = v;
    else if (z == 2'h1 && e) r[35:18] = (p != 0) ? v[17:0] : v[35:18];
    else if (z == 2'h1) r[17:0] = (p != 0) ? v[35:18] : v[17:0];
    else if (e) r[35:27] = 9'(v >> (9 * (3 - p)));
    else r[8:0] = 9'(v >> (9 * p));
    return r;
  endfunction : part

  task automatic cyc();
    @(posedge i_ref_clk);
    #1;
  endtask : cyc

  task automatic idle();
    a_wr = 1'b0;
    a_rd = 1'b0;
    b_sel_n = 1'b1;
    b_note = 1'b0;
    a_note = 1'b0;
  endtask : idle

  task automatic cmp_data(string nm, logic [35:0] e, logic [35:0] g);
    n_tests++;
    if (e !== g) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_data

  task automatic cmp_flag(string nm, logic [3:0] e, logic [3:0] g);
    n_tests++;
    if (e !== g) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_flag

  task automatic a_write(logic [35:0] v);
    a_wr = 1'b1;
    a_word = v;
    cyc();
  endtask : a_write

  task automatic a_read(logic [35:0] e);
    a_rd = 1'b1;
    a_note = 1'b1;
    qa.push_back(e);
    #1;
    cmp_flag("port_a_data_oe", 4'h1, {3'h0, a_oe});
    cyc();
  endtask : a_read

  task automatic b_op(logic wnr, logic [1:0] z, logic [35:0] d, logic note);
    b_sel_n = 1'b0;
    b_wnr = wnr;
    b_size = z;
    b_data = d;
    b_note = note;
    #1;
    cmp_flag("port_b_data_oe", {3'h0, !wnr}, {3'h0, b_oe});
    cyc();
  endtask : b_op

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // ==========================================================
  // Result watchers
  always @(posedge i_ref_clk) begin
    if (b_note === 1'b1) begin
      #2 cmp_data("port_b_data", qb.pop_front(), b_dout);
    end
  end

  always @(posedge i_ref_clk) begin
    if (a_note === 1'b1) begin
      #2 cmp_data("port_a_data", qa.pop_front(), a_dout);
    end
  end

  initial begin
    #500000;
    fail_count++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(90));
    repeat (3) @(posedge i_ref_clk);
    #1 i_reset = 1'b0;
    cmp_flag("port_a_flags", 4'b1010, fa);
    cmp_flag("port_b_flags", 4'b1010, fb);
    old = 36'h0;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 5; k++) begin
        sz = (k == 0) ? 2'h0 : ((k < 3) ? 2'h1 : 2'h2);
        bg = (k == 1 || k == 3);
        w = {4'($urandom), $urandom};
        a_write(w);
        idle();
        cyc();
        cmp_flag("port_b_empty_n", 4'h0, {3'h0, fb[0]});
        cyc();
        cmp_flag("port_b_empty_n", 4'h1, {3'h0, fb[0]});
        big = bg;
        b_swap = 2'(m);
        s = sw(w, 2'(m));
        np = (sz == 2'h0) ? 1 : ((sz == 2'h1) ? 2 : 4);
        for (int p = 0; p < np; p++) begin
          old = part(old, s, sz, bg, p);
          qb.push_back(old);
          b_op(1'b0, sz, 36'h0, 1'b1);
          cmp_flag("port_b_empty_n", {3'h0, p != np - 1}, {3'h0, fb[0]});
        end
        idle();
        cyc();
      end
    end
    // Mailbox read, then a read of the empty FIFO that must change nothing
    mbx = {4'($urandom), $urandom};
    qb.push_back(mbx);
    b_op(1'b0, 2'h3, 36'h0, 1'b1);
    qb.push_back(mbx);
    b_op(1'b0, 2'h0, 36'h0, 1'b1);
    idle();
    cyc();
    // Fill until refused, then drain
    for (int i = 0; i < 17; i++) begin
      w = {4'($urandom), $urandom};
      if (i < 16) fw[i] = w;
      a_write(w);
      cmp_flag("port_a_afull_full", {2'h0, i < 13, i < 15}, {2'h0, fa[3], fa[1]});
    end
    idle();
    cyc();
    b_swap = 2'h0;
    qb.push_back(fw[0]);
    b_op(1'b0, 2'h0, 36'h0, 1'b1);
    idle();
    cmp_flag("port_a_full_n", 4'h0, {3'h0, fa[1]});
    cyc();
    cmp_flag("port_a_full_n", 4'h0, {3'h0, fa[1]});
    cyc();
    cmp_flag("port_a_full_n", 4'h1, {3'h0, fa[1]});
    for (int i = 1; i < 16; i++) begin
      qb.push_back(fw[i]);
      b_op(1'b0, 2'h0, 36'h0, 1'b1);
      cmp_flag("a_afull_b_aempty", {2'h0, i >= 4, i < 13}, {2'h0, fa[3], fb[2]});
    end
    cmp_flag("port_b_empty_n", 4'h0, {3'h0, fb[0]});
    idle();
    cyc();
    // Port-B writes fill the other FIFO, last word in two halves
    big = 1'b1;
    for (int i = 0; i < 15; i++) begin
      fw[i] = {4'($urandom), $urandom};
      b_op(1'b1, 2'h0, fw[i], 1'b0);
      cmp_flag("a_flags_b_afull", {1'b0, i >= 4, i >= 2, i < 13}, {1'b0, fa[2], fa[0], fb[3]});
    end
    w = {4'($urandom), $urandom};
    fw[15] = w;
    b_op(1'b1, 2'h1, {w[35:18], ~w[17:0]}, 1'b0);
    cmp_flag("port_b_full_n", 4'h1, {3'h0, fb[1]});
    b_op(1'b1, 2'h1, {w[17:0], ~w[35:18]}, 1'b0);
    cmp_flag("port_b_full_n", 4'h0, {3'h0, fb[1]});
    idle();
    cyc();
    a_read(fw[0]);
    idle();
    cmp_flag("port_b_full_n", 4'h0, {3'h0, fb[1]});
    cyc();
    cmp_flag("port_b_full_n", 4'h0, {3'h0, fb[1]});
    cyc();
    cmp_flag("port_b_full_n", 4'h1, {3'h0, fb[1]});
    for (int i = 1; i < 16; i++) begin
      a_read(fw[i]);
      cmp_flag("b_afull_a_aempty", {2'h0, i >= 4, i < 13}, {2'h0, fb[3], fa[2]});
    end
    idle();
    cyc();
    cmp_flag("port_a_empty_n", 4'h0, {3'h0, fa[0]});
    close_out();
  end
endmodule : bidir_fifo_bus_match_flags_tb
